// ### src/aa_pkg.sv
// Shared types and constants of the arithmetic accelerator, both ends.
package aa_pkg;

	localparam int BYTE_W = 8;
	localparam int HALF_W = 16;
	localparam int WORD_W = 32;
	localparam int EXP_W  = 5;
	localparam int SEQ_LEN = 6;

	typedef enum logic [2:0] {SEL_OTHER, SEL_A, SEL_B, SEL_C, SEL_CTRL0} aa_sel_type;
	typedef enum logic [2:0] {OP_DIV32, OP_DIV16, OP_MUL, OP_SHIFT, OP_NORM} aa_op_type;

	// Operand byte counts that mark the points of a sequence.
	localparam logic [2:0] A_NONE       = 3'h0;
	localparam logic [2:0] A_ONE        = 3'h1;
	localparam logic [2:0] A_HALF_BYTES = 3'h2;
	localparam logic [2:0] A_THREE      = 3'h3;
	localparam logic [2:0] A_WORD_BYTES = 3'h4;
	localparam logic [1:0] B_NONE       = 2'h0;
	localparam logic [1:0] B_ONE        = 2'h1;
	localparam logic [1:0] B_HALF_BYTES = 2'h2;

	// Engine iteration counts.
	localparam logic [5:0] DIV32_STEPS = 6'h20;
	localparam logic [5:0] DIV16_STEPS = 6'h10;
	localparam logic [5:0] MUL_STEPS   = 6'h10;
	localparam logic [5:0] STEP_ONE    = 6'h01;

	// Worst-case execution times in clock periods.
	localparam int DIV32_LIMIT = 36;
	localparam int DIV16_LIMIT = 24;
	localparam int MUL_LIMIT   = 24;
	localparam int SHIFT_LIMIT = 36;
	localparam int NORM_LIMIT  = 36;

	// Control0 layout.
	localparam int         CTRL_LEFT_BIT  = 7;
	localparam int         CTRL_CNT_LSB   = 0;
	localparam int         CTRL_CNT_W     = 5;
	localparam logic [7:0] CTRL_NORMALIZE = 8'h00;

	localparam logic [7:0] RD_RESET = 8'h00;

endpackage

// ### src/aa_if.sv
// Special-function access channel between the core side and the accelerator.
`timescale 1ns/1ps
interface aa_if;
	logic                        accValid;
	logic                        accWrite;
	aa_pkg::aa_sel_type          accSel;
	logic [aa_pkg::BYTE_W-1:0]   accWrData;
	logic                        clearBusy;
	logic [aa_pkg::BYTE_W-1:0]   rdData;
	logic                        busy;

	modport dev (input accValid, accWrite, accSel, accWrData, clearBusy, output rdData, busy);
	modport host (output accValid, accWrite, accSel, accWrData, clearBusy, input rdData, busy);
endinterface

// ### src/aa_engine.sv
// Iterative datapath: restoring divide, shift-add multiply, shift and normalize.
`timescale 1ns/1ps
module aa_engine (
	// Clock and reset
	input  wire logic                         clock,
	input  wire logic                         rst,
	// Launch
	input  wire logic                         start,
	input  wire logic                         abort,
	input  wire aa_pkg::aa_op_type            op,
	input  wire logic [aa_pkg::WORD_W-1:0]    wordIn,
	input  wire logic [aa_pkg::HALF_W-1:0]    halfIn,
	input  wire logic [aa_pkg::BYTE_W-1:0]    ctrl,
	// Result
	output logic                              done,
	output logic [aa_pkg::WORD_W-1:0]         resWord,
	output logic [aa_pkg::HALF_W-1:0]         resHalf,
	output logic [aa_pkg::EXP_W-1:0]          resExp
);
	logic                      run_r;
	logic                      done_r;
	logic                      left_r;
	aa_pkg::aa_op_type         op_r;
	logic [aa_pkg::WORD_W-1:0] work_r;
	logic [aa_pkg::HALF_W:0]   rem_r;
	logic [aa_pkg::HALF_W-1:0] half_r;
	logic [5:0]                cnt_r;
	logic [aa_pkg::EXP_W-1:0]  exp_r;
	logic [aa_pkg::HALF_W:0]   divTrial;
	logic                      divFits;
	logic [aa_pkg::HALF_W:0]   mulSum;
	logic                      finished;

	assign divTrial = {rem_r[aa_pkg::HALF_W-1:0], work_r[aa_pkg::WORD_W-1]};
	assign divFits  = divTrial >= {1'b0, half_r};
	assign mulSum   = {1'b0, rem_r[aa_pkg::HALF_W-1:0]} + (work_r[0] ? {1'b0, half_r} : 17'h00000);
	// A zero operand never gains a leading one, so normalize then runs until aborted.
	assign finished = (op_r == aa_pkg::OP_NORM) ? work_r[aa_pkg::WORD_W-1] : (cnt_r == 6'h00);

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			run_r  <= 1'b0;
			done_r <= 1'b0;
			left_r <= 1'b0;
			op_r   <= aa_pkg::OP_DIV32;
			work_r <= 32'h00000000;
			rem_r  <= 17'h00000;
			half_r <= 16'h0000;
			cnt_r  <= 6'h00;
			exp_r  <= 5'h00;
		end else begin
			done_r <= 1'b0;
			if (abort) begin
				run_r <= 1'b0;
			end else if (start) begin
				run_r  <= 1'b1;
				op_r   <= op;
				work_r <= wordIn;
				half_r <= halfIn;
				rem_r  <= 17'h00000;
				exp_r  <= 5'h00;
				left_r <= ctrl[aa_pkg::CTRL_LEFT_BIT];
				unique case (op)
					aa_pkg::OP_DIV32: cnt_r <= aa_pkg::DIV32_STEPS;
					aa_pkg::OP_DIV16: cnt_r <= aa_pkg::DIV16_STEPS;
					aa_pkg::OP_MUL:   cnt_r <= aa_pkg::MUL_STEPS;
					aa_pkg::OP_SHIFT: cnt_r <= {1'b0, ctrl[aa_pkg::CTRL_CNT_LSB +: aa_pkg::CTRL_CNT_W]};
					aa_pkg::OP_NORM:  cnt_r <= 6'h00;
				endcase
			end else if (run_r) begin
				if (finished) begin
					run_r  <= 1'b0;
					done_r <= 1'b1;
				end else begin
					cnt_r <= cnt_r - aa_pkg::STEP_ONE;
					unique case (op_r)
						aa_pkg::OP_DIV32, aa_pkg::OP_DIV16: begin
							rem_r  <= divFits ? divTrial - {1'b0, half_r} : divTrial;
							work_r <= {work_r[aa_pkg::WORD_W-2:0], divFits};
						end
						aa_pkg::OP_MUL: begin
							rem_r  <= {1'b0, mulSum[aa_pkg::HALF_W:1]};
							work_r <= {work_r[aa_pkg::WORD_W-1:aa_pkg::HALF_W], mulSum[0], work_r[aa_pkg::HALF_W-1:1]};
						end
						aa_pkg::OP_SHIFT: begin
							work_r <= left_r ? {work_r[aa_pkg::WORD_W-2:0], 1'b0} : {1'b0, work_r[aa_pkg::WORD_W-1:1]};
						end
						aa_pkg::OP_NORM: begin
							work_r <= {work_r[aa_pkg::WORD_W-2:0], 1'b0};
							exp_r  <= exp_r + 5'h01;
						end
					endcase
				end
			end
		end
	end

	assign done    = done_r;
	assign resWord = (op_r == aa_pkg::OP_MUL) ? {rem_r[aa_pkg::HALF_W-1:0], work_r[aa_pkg::HALF_W-1:0]} : work_r;
	assign resHalf = rem_r[aa_pkg::HALF_W-1:0];
	assign resExp  = exp_r;
endmodule

// ### src/aa_accel_dev.sv
// Device end of the arithmetic accelerator: order sequencer, result ports and busy flag.
`timescale 1ns/1ps
module aa_accel_dev (
	// Clock and reset
	input  wire logic clock,
	input  wire logic rst,
	// Core access channel
	aa_if.dev         bus
);
	typedef enum logic [1:0] {ST_IDLE, ST_LOAD, ST_RUN, ST_ERROR} aa_seq_type;

	aa_seq_type                state_r;
	logic [2:0]                aCnt_r;
	logic [1:0]                bCnt_r;
	logic [aa_pkg::WORD_W-1:0] opA_r;
	logic [aa_pkg::HALF_W-1:0] opB_r;
	logic [aa_pkg::BYTE_W-1:0] ctrl_r;
	aa_pkg::aa_op_type         op_r;
	logic [aa_pkg::WORD_W-1:0] outA_r;
	logic [aa_pkg::HALF_W-1:0] outB_r;
	logic [aa_pkg::EXP_W-1:0]  exp_r;
	logic                      busy_r;
	logic [aa_pkg::BYTE_W-1:0] rdData_r;

	logic                      wr;
	logic                      rd;
	logic                      start;
	logic                      bad;
	aa_pkg::aa_op_type         opNow;
	logic [aa_pkg::WORD_W-1:0] engWord;
	logic [aa_pkg::HALF_W-1:0] engHalf;
	logic [aa_pkg::BYTE_W-1:0] engCtrl;
	logic                      engDone;
	logic [aa_pkg::WORD_W-1:0] engResWord;
	logic [aa_pkg::HALF_W-1:0] engResHalf;
	logic [aa_pkg::EXP_W-1:0]  engResExp;
	logic                      live;
	logic                      settled;

	assign wr      = bus.accValid && bus.accWrite;
	assign rd      = bus.accValid && !bus.accWrite;
	assign live    = (state_r != ST_ERROR) && !bus.clearBusy;
	assign settled = (state_r == ST_IDLE);

	// Decides, from the counts of bytes seen so far, whether an access extends,
	// completes or breaks the operand sequence.
	always_comb begin
		start   = 1'b0;
		bad     = 1'b0;
		opNow   = op_r;
		engWord = opA_r;
		engHalf = opB_r;
		engCtrl = ctrl_r;
		if (bus.accValid && live) begin
			unique case (bus.accSel)
				aa_pkg::SEL_A: begin
					if (!wr) begin
						bad = !settled;
					end else if (state_r == ST_RUN) begin
						bad = 1'b1;
					end else if (bCnt_r == aa_pkg::B_NONE && aCnt_r < aa_pkg::A_WORD_BYTES) begin
						bad = 1'b0;
					end else if (bCnt_r == aa_pkg::B_HALF_BYTES && aCnt_r < aa_pkg::A_HALF_BYTES) begin
						if (aCnt_r == aa_pkg::A_ONE) begin
							start   = 1'b1;
							opNow   = aa_pkg::OP_MUL;
							engWord = {16'h0000, opB_r};
							engHalf = {bus.accWrData, opA_r[aa_pkg::WORD_W-1 -: aa_pkg::BYTE_W]};
						end
					end else begin
						bad = 1'b1;
					end
				end
				aa_pkg::SEL_B: begin
					if (!wr) begin
						bad = !settled;
					end else if (state_r == ST_RUN) begin
						bad = 1'b1;
					end else if (bCnt_r < aa_pkg::B_HALF_BYTES && aCnt_r != aa_pkg::A_ONE
							&& aCnt_r != aa_pkg::A_THREE) begin
						if (bCnt_r == aa_pkg::B_ONE && aCnt_r != aa_pkg::A_NONE) begin
							start   = 1'b1;
							engHalf = {bus.accWrData, opB_r[aa_pkg::HALF_W-1 -: aa_pkg::BYTE_W]};
							if (aCnt_r == aa_pkg::A_WORD_BYTES) begin
								opNow   = aa_pkg::OP_DIV32;
								engWord = opA_r;
							end else begin
								opNow   = aa_pkg::OP_DIV16;
								engWord = {opA_r[aa_pkg::WORD_W-1 -: aa_pkg::HALF_W], 16'h0000};
							end
						end
					end else begin
						bad = 1'b1;
					end
				end
				aa_pkg::SEL_C: begin
					bad = !settled;
				end
				aa_pkg::SEL_CTRL0: begin
					if (!wr) begin
						bad = 1'b0;
					end else if (state_r == ST_RUN) begin
						bad = 1'b1;
					end else if (aCnt_r == aa_pkg::A_WORD_BYTES && bCnt_r == aa_pkg::B_NONE) begin
						start   = 1'b1;
						engCtrl = bus.accWrData;
						opNow   = (bus.accWrData == aa_pkg::CTRL_NORMALIZE) ? aa_pkg::OP_NORM : aa_pkg::OP_SHIFT;
					end else begin
						bad = (aCnt_r != aa_pkg::A_NONE) || (bCnt_r != aa_pkg::B_NONE);
					end
				end
				aa_pkg::SEL_OTHER: begin
					bad = 1'b0;
				end
				default: begin
					bad = 1'b0;
				end
			endcase
		end
	end

	// Sequencer state and operand byte counts.
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			state_r <= ST_IDLE;
			aCnt_r  <= aa_pkg::A_NONE;
			bCnt_r  <= aa_pkg::B_NONE;
			op_r    <= aa_pkg::OP_DIV32;
		end else if (bus.clearBusy) begin
			state_r <= ST_IDLE;
			aCnt_r  <= aa_pkg::A_NONE;
			bCnt_r  <= aa_pkg::B_NONE;
		end else if (bad) begin
			state_r <= ST_ERROR;
		end else if (start) begin
			state_r <= ST_RUN;
			op_r    <= opNow;
			aCnt_r  <= aa_pkg::A_NONE;
			bCnt_r  <= aa_pkg::B_NONE;
		end else if (state_r == ST_RUN && engDone) begin
			state_r <= ST_IDLE;
		end else if (wr && live && state_r != ST_RUN) begin
			if (bus.accSel == aa_pkg::SEL_A) begin
				aCnt_r  <= aCnt_r + aa_pkg::A_ONE;
				state_r <= ST_LOAD;
			end else if (bus.accSel == aa_pkg::SEL_B) begin
				bCnt_r  <= bCnt_r + aa_pkg::B_ONE;
				state_r <= ST_LOAD;
			end
		end
	end

	// Operand bytes enter at the top and shift down, so the last byte written lands on top.
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			opA_r  <= 32'h00000000;
			opB_r  <= 16'h0000;
			ctrl_r <= aa_pkg::CTRL_NORMALIZE;
		end else if (wr && live && !bad) begin
			if (bus.accSel == aa_pkg::SEL_A) begin
				opA_r <= {bus.accWrData, opA_r[aa_pkg::WORD_W-1:aa_pkg::BYTE_W]};
			end else if (bus.accSel == aa_pkg::SEL_B) begin
				opB_r <= {bus.accWrData, opB_r[aa_pkg::HALF_W-1:aa_pkg::BYTE_W]};
			end else if (bus.accSel == aa_pkg::SEL_CTRL0) begin
				ctrl_r <= bus.accWrData;
			end
		end
	end

	// Result ports: each read of A or B hands out the top byte and moves the next one up.
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			outA_r   <= 32'h00000000;
			outB_r   <= 16'h0000;
			exp_r    <= 5'h00;
			rdData_r <= aa_pkg::RD_RESET;
		end else if (state_r == ST_RUN && engDone && !bus.clearBusy) begin
			outA_r <= (op_r == aa_pkg::OP_DIV16) ? {engResWord[aa_pkg::HALF_W-1:0], 16'h0000} : engResWord;
			outB_r <= engResHalf;
			exp_r  <= engResExp;
		end else if (rd && live && !bad) begin
			unique case (bus.accSel)
				aa_pkg::SEL_A: begin
					rdData_r <= outA_r[aa_pkg::WORD_W-1 -: aa_pkg::BYTE_W];
					outA_r   <= {outA_r[aa_pkg::WORD_W-aa_pkg::BYTE_W-1:0], 8'h00};
				end
				aa_pkg::SEL_B: begin
					rdData_r <= outB_r[aa_pkg::HALF_W-1 -: aa_pkg::BYTE_W];
					outB_r   <= {outB_r[aa_pkg::BYTE_W-1:0], 8'h00};
				end
				aa_pkg::SEL_CTRL0: rdData_r <= {3'h0, exp_r};
				aa_pkg::SEL_C:     rdData_r <= aa_pkg::RD_RESET;
				aa_pkg::SEL_OTHER: rdData_r <= rdData_r;
				default:           rdData_r <= rdData_r;
			endcase
		end
	end

	// Busy rises with the completing or faulty access and falls as results load.
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			busy_r <= 1'b0;
		end else if (bus.clearBusy) begin
			busy_r <= 1'b0;
		end else if (bad || start) begin
			busy_r <= 1'b1;
		end else if (state_r == ST_RUN && engDone) begin
			busy_r <= 1'b0;
		end
	end

	aa_engine engine (
		.clock   (clock),
		.rst     (rst),
		.start   (start),
		.abort   (bus.clearBusy),
		.op      (opNow),
		.wordIn  (engWord),
		.halfIn  (engHalf),
		.ctrl    (engCtrl),
		.done    (engDone),
		.resWord (engResWord),
		.resHalf (engResHalf),
		.resExp  (engResExp)
	);

	assign bus.busy   = busy_r;
	assign bus.rdData = rdData_r;
endmodule

// ### src/aa_host.sv
// Core-side end: plays a command out as ordered port accesses and collects the result.
`timescale 1ns/1ps
module aa_host (
	// Clock and reset
	input  wire logic                      clock,
	input  wire logic                      rst,
	// Accelerator channel
	aa_if.host                             bus,
	// Command from the user
	input  wire logic                      cmdValid,
	input  wire aa_pkg::aa_op_type         cmdOp,
	input  wire logic [aa_pkg::WORD_W-1:0] cmdWord,
	input  wire logic [aa_pkg::HALF_W-1:0] cmdHalf,
	input  wire logic [aa_pkg::BYTE_W-1:0] cmdCtrl,
	input  wire logic                      abort,
	output logic                           cmdReady,
	// Result to the user
	output logic                           resValid,
	output logic [aa_pkg::WORD_W-1:0]      resWord,
	output logic [aa_pkg::HALF_W-1:0]      resHalf,
	output logic [aa_pkg::EXP_W-1:0]       resExp
);
	typedef enum logic [2:0] {H_IDLE, H_WRITE, H_SETTLE, H_POLL, H_READ, H_RWAIT, H_CAPT, H_DONE} aa_host_type;

	aa_host_type               state_r;
	aa_pkg::aa_sel_type        wrSel_r [0:aa_pkg::SEQ_LEN-1];
	logic [aa_pkg::BYTE_W-1:0] wrData_r [0:aa_pkg::SEQ_LEN-1];
	aa_pkg::aa_sel_type        rdSel_r [0:aa_pkg::SEQ_LEN-1];
	logic [2:0]                nWr_r;
	logic [2:0]                nRd_r;
	logic [2:0]                idx_r;
	logic                      accValid_r;
	logic                      accWrite_r;
	aa_pkg::aa_sel_type        accSel_r;
	logic [aa_pkg::BYTE_W-1:0] accWrData_r;
	logic                      clearBusy_r;
	logic                      cmdReady_r;
	logic                      resValid_r;
	logic [aa_pkg::WORD_W-1:0] resWord_r;
	logic [aa_pkg::HALF_W-1:0] resHalf_r;
	logic [aa_pkg::EXP_W-1:0]  resExp_r;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			state_r     <= H_IDLE;
			nWr_r       <= 3'h0;
			nRd_r       <= 3'h0;
			idx_r       <= 3'h0;
			accValid_r  <= 1'b0;
			accWrite_r  <= 1'b0;
			accSel_r    <= aa_pkg::SEL_OTHER;
			accWrData_r <= 8'h00;
			clearBusy_r <= 1'b0;
			cmdReady_r  <= 1'b1;
			resValid_r  <= 1'b0;
			resWord_r   <= 32'h00000000;
			resHalf_r   <= 16'h0000;
			resExp_r    <= 5'h00;
			for (int i = 0; i < aa_pkg::SEQ_LEN; i++) begin
				wrSel_r[i]  <= aa_pkg::SEL_A;
				wrData_r[i] <= 8'h00;
				rdSel_r[i]  <= aa_pkg::SEL_A;
			end
		end else begin
			clearBusy_r <= 1'b0;
			resValid_r  <= 1'b0;
			if (abort) begin
				clearBusy_r <= 1'b1;
				accValid_r  <= 1'b0;
				cmdReady_r  <= 1'b1;
				state_r     <= H_IDLE;
			end else begin
				unique case (state_r)
					H_IDLE: begin
						if (cmdValid) begin
							cmdReady_r <= 1'b0;
							idx_r      <= 3'h0;
							resWord_r  <= 32'h00000000;
							resHalf_r  <= 16'h0000;
							resExp_r   <= 5'h00;
							state_r    <= H_WRITE;
							for (int i = 0; i < aa_pkg::SEQ_LEN; i++) begin
								rdSel_r[i] <= aa_pkg::SEL_A;
							end
							for (int i = 0; i < 4; i++) begin
								wrSel_r[i]  <= aa_pkg::SEL_A;
								wrData_r[i] <= cmdWord[i*aa_pkg::BYTE_W +: aa_pkg::BYTE_W];
							end
							wrSel_r[4]  <= aa_pkg::SEL_B;
							wrData_r[4] <= cmdHalf[7:0];
							wrSel_r[5]  <= aa_pkg::SEL_B;
							wrData_r[5] <= cmdHalf[15:8];
							nWr_r       <= 3'h6;
							nRd_r       <= 3'h4;
							unique case (cmdOp)
								aa_pkg::OP_DIV32: begin
									nRd_r      <= 3'h6;
									rdSel_r[4] <= aa_pkg::SEL_B;
									rdSel_r[5] <= aa_pkg::SEL_B;
								end
								aa_pkg::OP_DIV16: begin
									wrSel_r[2]  <= aa_pkg::SEL_B;
									wrData_r[2] <= cmdHalf[7:0];
									wrSel_r[3]  <= aa_pkg::SEL_B;
									wrData_r[3] <= cmdHalf[15:8];
									nWr_r       <= 3'h4;
									rdSel_r[2]  <= aa_pkg::SEL_B;
									rdSel_r[3]  <= aa_pkg::SEL_B;
								end
								aa_pkg::OP_MUL: begin
									wrSel_r[0]  <= aa_pkg::SEL_B;
									wrData_r[0] <= cmdHalf[7:0];
									wrSel_r[1]  <= aa_pkg::SEL_B;
									wrData_r[1] <= cmdHalf[15:8];
									wrData_r[2] <= cmdWord[7:0];
									wrData_r[3] <= cmdWord[15:8];
									nWr_r       <= 3'h4;
								end
								aa_pkg::OP_SHIFT: begin
									wrSel_r[4]  <= aa_pkg::SEL_CTRL0;
									wrData_r[4] <= cmdCtrl;
									nWr_r       <= 3'h5;
								end
								aa_pkg::OP_NORM: begin
									wrSel_r[4]  <= aa_pkg::SEL_CTRL0;
									wrData_r[4] <= aa_pkg::CTRL_NORMALIZE;
									nWr_r       <= 3'h5;
									nRd_r       <= 3'h5;
									rdSel_r[4]  <= aa_pkg::SEL_CTRL0;
									if (cmdWord == 32'h00000000) begin
										state_r <= H_DONE;
									end
								end
							endcase
						end
					end
					H_WRITE: begin
						accValid_r  <= 1'b1;
						accWrite_r  <= 1'b1;
						accSel_r    <= wrSel_r[idx_r];
						accWrData_r <= wrData_r[idx_r];
						idx_r       <= idx_r + 3'h1;
						if (idx_r == nWr_r - 3'h1) begin
							state_r <= H_SETTLE;
						end
					end
					H_SETTLE: begin
						accValid_r <= 1'b0;
						idx_r      <= 3'h0;
						state_r    <= H_POLL;
					end
					H_POLL: begin
						if (!bus.busy) begin
							state_r <= H_READ;
						end
					end
					H_READ: begin
						accValid_r <= 1'b1;
						accWrite_r <= 1'b0;
						accSel_r   <= rdSel_r[idx_r];
						state_r    <= H_RWAIT;
					end
					H_RWAIT: begin
						accValid_r <= 1'b0;
						state_r    <= H_CAPT;
					end
					H_CAPT: begin
						if (accSel_r == aa_pkg::SEL_A) begin
							resWord_r <= {resWord_r[23:0], bus.rdData};
						end else if (accSel_r == aa_pkg::SEL_B) begin
							resHalf_r <= {resHalf_r[7:0], bus.rdData};
						end else begin
							resExp_r <= bus.rdData[aa_pkg::EXP_W-1:0];
						end
						idx_r   <= idx_r + 3'h1;
						state_r <= (idx_r == nRd_r - 3'h1) ? H_DONE : H_READ;
					end
					H_DONE: begin
						resValid_r <= 1'b1;
						cmdReady_r <= 1'b1;
						state_r    <= H_IDLE;
					end
				endcase
			end
		end
	end

	assign bus.accValid  = accValid_r;
	assign bus.accWrite  = accWrite_r;
	assign bus.accSel    = accSel_r;
	assign bus.accWrData = accWrData_r;
	assign bus.clearBusy = clearBusy_r;
	assign cmdReady      = cmdReady_r;
	assign resValid      = resValid_r;
	assign resWord       = resWord_r;
	assign resHalf       = resHalf_r;
	assign resExp        = resExp_r;
endmodule

// ### test/aa_chk.sv
// Concurrent checks on the accelerator access channel.
`timescale 1ns/1ps
module aa_chk (
	// Clock and reset
	input wire logic               clock,
	input wire logic               rst,
	// Channel
	input wire logic               accValid,
	input wire logic               accWrite,
	input wire aa_pkg::aa_sel_type accSel,
	input wire logic [7:0]         accWrData,
	input wire logic               clearBusy,
	input wire logic [7:0]         rdData,
	input wire logic               busy
);
	logic wrA;
	logic wrB;
	logic wrC0;
	assign wrA = accValid && accWrite && accSel == aa_pkg::SEL_A;
	assign wrB = accValid && accWrite && accSel == aa_pkg::SEL_B;
	assign wrC0 = accValid && accWrite && accSel == aa_pkg::SEL_CTRL0;
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (rst);
	AST_MUL: assert property (wrB [*2] ##1 wrA [*2] |=> busy ##[1:23] !busy)
		else $error("multiply busy span wrong");
	AST_DIV32: assert property (wrA [*4] ##1 wrB [*2] |=> busy ##[1:35] !busy)
		else $error("divide busy span wrong");
	AST_DIV16: assert property (!wrA ##1 wrA [*2] ##1 wrB [*2] |=> busy ##[1:23] !busy)
		else $error("short divide busy span wrong");
	AST_NORM: assert property (wrA [*4] ##1 (wrC0 && accWrData == 8'h00) |=> busy ##[1:35] !busy)
		else $error("normalize busy span wrong");
	AST_SHIFT: assert property (wrA [*4] ##1 (wrC0 && accWrData != 8'h00) |=> busy ##[1:35] !busy)
		else $error("shift busy span wrong");
	AST_CAUSE: assert property ($rose(busy) |-> $past(accValid && !clearBusy))
		else $error("busy rose without an access");
	AST_CLEAR: assert property (clearBusy |=> !busy)
		else $error("busy not cleared");
	AST_RDHOLD: assert property (!(accValid && !accWrite) |=> $stable(rdData))
		else $error("read data moved without a read");
	AST_QUIET: assert property (busy |-> !(accValid && accSel != aa_pkg::SEL_OTHER))
		else $error("access while busy");
	AST_BOUND: assert property ($rose(busy) |-> ##[0:35] !busy)
		else $error("busy held too long");
endmodule

// ### test/arithmetic_accelerator_tb.sv
// Self-checking bench joining the host and device ends of the accelerator.
`timescale 1ns/1ps
module arithmetic_accelerator_tb;
	logic              clock = 1'b0;
	logic              rst = 1'b1;
	logic              cmdValid = 1'b0;
	aa_pkg::aa_op_type cmdOp = aa_pkg::OP_MUL;
	logic [31:0]       cmdWord = 32'h0;
	logic [15:0]       cmdHalf = 16'h0;
	logic [7:0]        cmdCtrl = 8'h0;
	logic              abort = 1'b0;
	logic              cmdReady;
	logic              resValid;
	logic [31:0]       resWord;
	logic [15:0]       resHalf;
	logic [4:0]        resExp;
	int                n_fail = 0;
	int                n_compared = 0;
	aa_if bus ();
	aa_accel_dev aa_accel_dev_inst (.clock(clock), .rst(rst), .bus(bus.dev));
	aa_host aa_host_inst (.clock(clock), .rst(rst), .bus(bus.host), .cmdValid(cmdValid), .cmdOp(cmdOp),
		.cmdWord(cmdWord), .cmdHalf(cmdHalf), .cmdCtrl(cmdCtrl), .abort(abort), .cmdReady(cmdReady),
		.resValid(resValid), .resWord(resWord), .resHalf(resHalf), .resExp(resExp));
	aa_chk aa_chk_inst (.clock(clock), .rst(rst), .accValid(bus.accValid), .accWrite(bus.accWrite),
		.accSel(bus.accSel), .accWrData(bus.accWrData), .clearBusy(bus.clearBusy), .rdData(bus.rdData),
		.busy(bus.busy));
	always #2.5 clock = ~clock;
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Issues one command; waits for the result unless an abort is due.
	task automatic go(input aa_pkg::aa_op_type op, input logic [31:0] w, input logic [15:0] h, input logic [7:0] c,
		input bit stop);
		int k;
		k = 0;
		while (cmdReady !== 1'b1 && k < 200) begin
			@(negedge clock);
			k++;
		end
		cmdOp = op;
		cmdWord = w;
		cmdHalf = h;
		cmdCtrl = c;
		cmdValid = 1'b1;
		@(negedge clock);
		cmdValid = 1'b0;
		if (stop) begin
			repeat (12) @(negedge clock);
			abort = 1'b1;
			@(negedge clock);
			abort = 1'b0;
			repeat (3) @(negedge clock);
		end else begin
			while (resValid !== 1'b1 && k < 400) begin
				@(negedge clock);
				k++;
			end
			cmp({31'h0, resValid}, 32'h1);
			cmp({31'h0, cmdReady}, 32'h1);
		end
	endtask
	task automatic t_div();
		go(aa_pkg::OP_DIV32, 32'h12345678, 16'h0010, 8'h00, 1'b0);
		cmp(resWord, 32'h01234567);
		cmp({16'h0, resHalf}, 32'h8);
		go(aa_pkg::OP_DIV16, 32'h0000ABCD, 16'h0100, 8'h00, 1'b0);
		cmp(resWord, 32'h000000AB);
		cmp({16'h0, resHalf}, 32'hCD);
		$display("test divide done");
	endtask
	task automatic t_mul_shift();
		go(aa_pkg::OP_MUL, 32'h0000FFFF, 16'hFFFF, 8'h00, 1'b0);
		cmp(resWord, 32'hFFFE0001);
		go(aa_pkg::OP_SHIFT, 32'h0F00000F, 16'h0, 8'h84, 1'b0);
		cmp(resWord, 32'hF00000F0);
		go(aa_pkg::OP_SHIFT, 32'h80000000, 16'h0, 8'h1F, 1'b0);
		cmp(resWord, 32'h00000001);
		$display("test multiply and shift done");
	endtask
	task automatic t_norm();
		go(aa_pkg::OP_NORM, 32'h00001000, 16'h0, 8'h00, 1'b0);
		cmp(resWord, 32'h80000000);
		cmp({27'h0, resExp}, 32'h13);
		go(aa_pkg::OP_NORM, 32'h00000000, 16'h0, 8'h00, 1'b0);
		cmp(resWord, 32'h0);
		cmp({27'h0, resExp}, 32'h0);
		$display("test normalize done");
	endtask
	// Resets between commands, while results from the previous test still stand.
	task automatic t_reset();
		@(negedge clock);
		rst = 1'b1;
		repeat (2) @(negedge clock);
		rst = 1'b0;
		cmp(resWord, 32'h0);
		cmp({27'h0, resExp}, 32'h0);
		cmp({31'h0, cmdReady}, 32'h1);
		cmp({31'h0, bus.busy}, 32'h0);
		cmp({24'h0, bus.rdData}, 32'h0);
		$display("test reset done");
	endtask
	task automatic t_abort();
		go(aa_pkg::OP_DIV32, 32'hFFFF0000, 16'h0003, 8'h00, 1'b1);
		cmp({31'h0, bus.busy}, 32'h0);
		go(aa_pkg::OP_MUL, 32'h00001234, 16'h0010, 8'h00, 1'b0);
		cmp(resWord, 32'h00012340);
		$display("test abort done");
	endtask
	task automatic results();
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	initial begin
		#100000;
		n_fail++;
		results();
	end
	initial begin
		repeat (4) @(posedge clock);
		@(negedge clock);
		rst = 1'b0;
		t_div();
		t_mul_shift();
		t_reset();
		t_norm();
		t_abort();
		results();
	end
endmodule
